//--- hw/timebase_pkg.sv
/*
  Package for the dual timebase generator: register map, field layout,
  divider constants and filter timing.
  Assumes a plain word-wide register port with a 9-bit byte address.
*/
package timebase_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  // Byte offsets inside the 512-byte space
  localparam logic [8:0] MCR_OFS = 9'h000;
  localparam logic [8:0] IRQ_CFG_OFS = 9'h008;
  localparam logic [8:0] T1_CNT_OFS = 9'h040;
  localparam logic [8:0] T2_CNT_OFS = 9'h042;
  // Field positions in the module configuration register
  localparam int STOP_BIT = 15;
  localparam int T1DIV_LO = 13;
  localparam int T2DIV_LO = 11;
  localparam int STF_BIT = 8;
  localparam int EMU_BIT = 7;
  localparam int GATE_BIT = 6;
  localparam int CCS_BIT = 5;
  // Field positions in the interrupt configuration register
  localparam int IRQ_LVL_LO = 8;
  localparam int IRQ_VEC_LO = 4;
  // Divider figures
  localparam int COARSE_SLOW = 32;
  localparam int COARSE_FAST = 4;
  localparam int DIV_EIGHT = 8;
  localparam int DIV_CNT_W = 5;
  // Noise filter: pin must be stable this long to count
  localparam int FILT_NS = 40;
  localparam int CLK_NS = 10;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // Configuration carried to the timebase core
  typedef struct packed {
    logic stop;
    logic coarse_clock_select;
    logic gate_mode_select;
    logic [1:0] timebase_one_divide;
    logic [1:0] timebase_two_divide;
  } tb_cfg_t;
endpackage

//--- hw/prescale_stage.sv
/*
  Binary prescaler: pulses once every 1, 2, 4 or 8 input ticks.
  Assumes tick_in is a one-cycle pulse in the ref_clk domain.
*/
`timescale 1ns/100ps
module prescale_stage (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic tick_in,
  input wire logic [1:0] code,
  output logic tick_out
);
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] limit;
  logic tick_out_nxt;

  // Limit is 2**code - 1
  always_comb
  begin
    limit = 3'((4'h1 << code) - 4'h1);
    cnt_nxt = cnt_r;
    tick_out_nxt = 1'b0;
    if (tick_in)
    begin
      if (cnt_r >= limit)
      begin
        cnt_nxt = 3'h0;
        tick_out_nxt = 1'b1;
      end
      else
        cnt_nxt = 3'(cnt_r + 3'h1);
    end
  end

  // Cleared by module reset
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cnt_r <= 3'h0;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_out_nxt;
    end
  end
endmodule // prescale_stage

//--- hw/dual_timebase_prescaler.sv
/*
  Dual timebase generator with its configuration registers.
  Assumes a single-cycle register port, read data one cycle later,
  and an external timebase pin that may be asynchronous.
*/
// Contract
// [RULE1] Host uses word accesses only
// [RULE2] Decode 512 bytes, unused reads zero
// [RULE3] Coarse divide 32 or 4 by select
// [RULE4] First prescaler divides by 1,2,4,8
// [RULE5] Gate bit picks pin clock or gate
// [RULE6] Gated mode, pin low blocks counting
// [RULE7] Gated mode, pin high counts div-eight
// [RULE8] Clock mode syncs and filters the pin
// [RULE9] Second prescaler 1,2,4,8 after source
// [RULE10] Hold interrupt level and vector
// [RULE11] Emulation bit writable once after reset
// [RULE12] Stop freezes counters, sets stop flag
// [RULE13] 16-bit wrapping counters, reset clears
`timescale 1ns/100ps
module dual_timebase_prescaler #(
  parameter int CNT_W = timebase_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [timebase_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timebase_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [timebase_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ext_timebase_pin,
  output logic emulation_enable,
  output logic stop_flag
);
  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  timebase_pkg::tb_cfg_t cfg_r, cfg_nxt;
  logic emu_r, emu_nxt;
  logic emu_locked_r, emu_locked_nxt;
  logic [2:0] irq_level_r, irq_level_nxt;
  logic [3:0] irq_vector_r, irq_vector_nxt;
  logic [15:0] rdata_nxt;
  logic stop_flag_nxt;
  logic [CNT_W-1:0] timebase_one_counter_r, timebase_one_counter_nxt;
  logic [CNT_W-1:0] timebase_two_counter_r, timebase_two_counter_nxt;
  logic [15:0] mcr_view;

  assign mcr_view = {cfg_r.stop, cfg_r.timebase_one_divide, cfg_r.timebase_two_divide,
                     2'b00, stop_flag, emu_r, cfg_r.gate_mode_select,
                     cfg_r.coarse_clock_select, 5'h00};

  // Register writes; byte lanes do not exist, so all accesses are words
  always_comb
  begin
    cfg_nxt = cfg_r;
    emu_nxt = emu_r;
    emu_locked_nxt = emu_locked_r;
    irq_level_nxt = irq_level_r;
    irq_vector_nxt = irq_vector_r;
    if (reg_wr) // RULE1
    begin
      if (reg_addr == timebase_pkg::MCR_OFS)
      begin
        cfg_nxt.stop = reg_wdata[timebase_pkg::STOP_BIT];
        cfg_nxt.timebase_one_divide = reg_wdata[timebase_pkg::T1DIV_LO +: 2];
        cfg_nxt.timebase_two_divide = reg_wdata[timebase_pkg::T2DIV_LO +: 2];
        cfg_nxt.gate_mode_select = reg_wdata[timebase_pkg::GATE_BIT];
        cfg_nxt.coarse_clock_select = reg_wdata[timebase_pkg::CCS_BIT];
        if (!emu_locked_r)
        begin
          emu_nxt = reg_wdata[timebase_pkg::EMU_BIT]; // RULE11
          emu_locked_nxt = 1'b1; // RULE11
        end
      end
      else if (reg_addr == timebase_pkg::IRQ_CFG_OFS)
      begin
        irq_level_nxt = reg_wdata[timebase_pkg::IRQ_LVL_LO +: 3]; // RULE10
        irq_vector_nxt = reg_wdata[timebase_pkg::IRQ_VEC_LO +: 4]; // RULE10
      end
    end
  end

  // Read mux; anything unmapped in the space reads zero
  always_comb
  begin
    rdata_nxt = timebase_pkg::ZERO_WORD;
    if (reg_rd)
    begin
      if (reg_addr == timebase_pkg::MCR_OFS)
        rdata_nxt = mcr_view;
      else if (reg_addr == timebase_pkg::IRQ_CFG_OFS)
        rdata_nxt = {5'h00, irq_level_r, irq_vector_r, 4'h0};
      else if (reg_addr == timebase_pkg::T1_CNT_OFS)
        rdata_nxt = 16'(timebase_one_counter_r);
      else if (reg_addr == timebase_pkg::T2_CNT_OFS)
        rdata_nxt = 16'(timebase_two_counter_r);
      else
        rdata_nxt = timebase_pkg::ZERO_WORD; // RULE2
    end
  end

  // Config and read data flops; read data fall back to zero next cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cfg_r <= '0;
      emu_r <= 1'b0;
      emu_locked_r <= 1'b0;
      irq_level_r <= 3'h0;
      irq_vector_r <= 4'h0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      emu_r <= emu_nxt;
      emu_locked_r <= emu_locked_nxt;
      irq_level_r <= irq_level_nxt;
      irq_vector_r <= irq_vector_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal dividers: one free counter gives /4, /8 and /32 ticks
  logic [timebase_pkg::DIV_CNT_W-1:0] div_r, div_nxt;
  logic coarse_tick, sysclk_div_eight;
  localparam logic [4:0] SLOW_LAST = 5'(timebase_pkg::COARSE_SLOW - 1);
  localparam logic [4:0] FAST_MASK = 5'(timebase_pkg::COARSE_FAST - 1);
  localparam logic [4:0] EIGHT_MASK = 5'(timebase_pkg::DIV_EIGHT - 1);

  // Stop halts the divider too, so no partial period leaks through
  always_comb
  begin
    div_nxt = cfg_r.stop ? div_r : 5'(div_r + 5'h01); // RULE12
    if (cfg_r.stop)
    begin
      coarse_tick = 1'b0;
      sysclk_div_eight = 1'b0;
    end
    else
    begin
      coarse_tick = cfg_r.coarse_clock_select ? ((div_r & FAST_MASK) == FAST_MASK)
                                              : (div_r == SLOW_LAST); // RULE3
      sysclk_div_eight = ((div_r & EIGHT_MASK) == EIGHT_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and noise filter
  logic pin_meta_r, pin_sync_r, filt_r, filt_d_r;
  logic [3:0] filt_cnt_r, filt_cnt_nxt;
  logic filt_nxt;
  localparam logic [3:0] FILT_LAST = 4'(timebase_pkg::FILT_CYC - 1);

  // Level must hold for the filter time before it is believed
  always_comb
  begin
    filt_nxt = filt_r;
    filt_cnt_nxt = 4'h0;
    if (pin_sync_r != filt_r)
    begin
      if (filt_cnt_r >= FILT_LAST)
        filt_nxt = pin_sync_r; // RULE8
      else
        filt_cnt_nxt = 4'(filt_cnt_r + 4'h1);
    end
  end

  // Divider, two-flop synchroniser and filter state
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      div_r <= 5'h00;
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      filt_r <= 1'b0;
      filt_d_r <= 1'b0;
      filt_cnt_r <= 4'h0;
    end
    else
    begin
      div_r <= div_nxt;
      pin_meta_r <= ext_timebase_pin; // RULE8
      pin_sync_r <= pin_meta_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
      filt_cnt_r <= filt_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source selection and prescalers
  logic t2_src, t1_tick, t2_tick, ext_rise;
  assign ext_rise = filt_r & ~filt_d_r;

  // Gate mode uses the filtered level, so gate glitches are rejected too
  always_comb
  begin
    if (cfg_r.stop)
      t2_src = 1'b0; // RULE12
    else if (cfg_r.gate_mode_select) // RULE5
      t2_src = sysclk_div_eight & filt_r; // RULE6 RULE7
    else
      t2_src = ext_rise; // RULE8
  end

  prescale_stage u_pre_one (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick_in(coarse_tick),
    .code(cfg_r.timebase_one_divide), // RULE4
    .tick_out(t1_tick)
  );

  prescale_stage u_pre_two (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick_in(t2_src),
    .code(cfg_r.timebase_two_divide), // RULE9
    .tick_out(t2_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Timebase counters and stop flag
  always_comb
  begin
    timebase_one_counter_nxt = timebase_one_counter_r;
    timebase_two_counter_nxt = timebase_two_counter_r;
    if (t1_tick && !cfg_r.stop)
      timebase_one_counter_nxt = CNT_W'(timebase_one_counter_r + 1'b1); // RULE13
    if (t2_tick && !cfg_r.stop)
      timebase_two_counter_nxt = CNT_W'(timebase_two_counter_r + 1'b1); // RULE13
    stop_flag_nxt = cfg_r.stop; // RULE12
  end

  // Counter and status flops
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      timebase_one_counter_r <= '0; // RULE13
      timebase_two_counter_r <= '0;
      stop_flag <= 1'b0;
      emulation_enable <= 1'b0;
    end
    else
    begin
      timebase_one_counter_r <= timebase_one_counter_nxt;
      timebase_two_counter_r <= timebase_two_counter_nxt;
      stop_flag <= stop_flag_nxt;
      emulation_enable <= emu_nxt;
    end
  end
endmodule // dual_timebase_prescaler

//--- tb/pin_source.sv
/* Source for the external timebase pin: steady levels and pulse trains.
   Assumes ref_clk paces it; the pin has no pull, the model always drives it. */
`timescale 1ns/100ps
module pin_source (
  input wire logic ref_clk,
  output logic pin
);
  initial pin = 1'b0;
  // Called just after an edge, so the level moves off the sampling edge
  task automatic level(input logic v);
    pin <= v;
  endtask
  // Whole pulse, hi cycles high then lo cycles low
  task automatic pulse(input int hi, input int lo);
    @(posedge ref_clk);
    pin <= 1'b1;
    repeat (hi) @(posedge ref_clk);
    pin <= 1'b0;
    repeat (lo) @(posedge ref_clk);
  endtask
endmodule // pin_source

//--- tb/timebase_props.sv
/* Checker for the timebase block's register port and status pins.
   Assumes a bind to the top module; sees its ports only. */
`timescale 1ns/100ps
module timebase_props #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic ext_timebase_pin,
  input wire logic emulation_enable,
  input wire logic stop_flag
);
  localparam logic [8:0] MCR = timebase_pkg::MCR_OFS;
  localparam logic [8:0] IRQ = timebase_pkg::IRQ_CFG_OFS;
  logic wrote_r, wrote_nxt, mw, t1r, fast, hole;
  logic [15:0] mcr_r, mcr_nxt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  assign mw = reg_wr && reg_addr == MCR;
  assign t1r = reg_rd && reg_addr == timebase_pkg::T1_CNT_OFS;
  assign fast = mcr_r[15:13] == 3'h0 && mcr_r[5];
  assign hole = reg_rd && !(reg_addr inside {MCR, IRQ, 9'h040, 9'h042});
  // Shadow of the last config write; the step check needs the live divider
  always_comb
  begin
    wrote_nxt = wrote_r | mw;
    mcr_nxt = mw ? reg_wdata : mcr_r;
  end
  always_ff @(posedge ref_clk)
  begin
    wrote_r <= reset_n & wrote_nxt;
    mcr_r <= reset_n ? mcr_nxt : 16'h0000;
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");
  a_hole_zero: assert property (hole |=> reg_rdata == 16'h0000)
    else $error("unused place not zero");
  a_stop_flag: assert property (mw && reg_wdata[15] |-> ##[1:2] stop_flag)
    else $error("stop flag missing");
  a_stop_read: assert property ((reg_rd && reg_addr == MCR) ##1 $stable(stop_flag) |->
    reg_rdata[8] == stop_flag) else $error("stop bit readback");
  a_emu_cause: assert property ($changed(emulation_enable) |-> $past(mw))
    else $error("emulation bit moved alone");
  a_emu_lock: assert property ($past(wrote_r) |-> $stable(emulation_enable))
    else $error("emulation bit rewritten");
  a_irq_keep: assert property ((reg_wr && reg_addr == IRQ) ##1 (reg_rd && reg_addr == IRQ)
    |=> reg_rdata[10:4] == $past(reg_wdata[10:4], 2)) else $error("irq config lost");
  a_t1_step: assert property ((t1r && fast) ##4 (t1r && fast) |=>
    reg_rdata == $past(reg_rdata, 4) + 16'h0001) else $error("counter one rate");
  c_t1: cover property (t1r && fast);
  c_stop: cover property ($rose(stop_flag));
  c_emu: cover property ($rose(emulation_enable));
  c_pin: cover property ($rose(ext_timebase_pin));
endmodule // timebase_props
bind dual_timebase_prescaler timebase_props #(.CNT_W(CNT_W)) timebase_props_inst (.ref_clk,
  .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_timebase_pin,
  .emulation_enable, .stop_flag);

//--- tb/dual_timebase_prescaler_tb_top.sv
/* Bench for the timebase block: bus driver, read-result queue, pin source.
   Assumes read data stand exactly one cycle after the read strobe. */
`timescale 1ns/100ps
module dual_timebase_prescaler_tb_top;
  localparam logic [8:0] MCR = timebase_pkg::MCR_OFS;
  localparam logic [8:0] IRQ = timebase_pkg::IRQ_CFG_OFS;
  localparam logic [8:0] T1 = timebase_pkg::T1_CNT_OFS;
  localparam logic [8:0] T2 = timebase_pkg::T2_CNT_OFS;
  logic ref_clk, reset_n, reg_wr, reg_rd, rd_d, pin, emulation_enable, stop_flag;
  logic [8:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, lfsr, a, b, c;
  logic [31:0] note, exp_q[$];
  logic [15:0] got_q[$];
  int fails = 0, n_compared = 0;
  dual_timebase_prescaler dual_timebase_prescaler_inst (.ref_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_timebase_pin(pin), .emulation_enable,
    .stop_flag);
  pin_source pin_source_inst (.ref_clk, .pin);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] cfg(logic s, logic [1:0] d1, logic [1:0] d2, logic g, logic c);
    return {s, d1, d2, 4'h0, g, c, 5'h00};
  endfunction
  // Stimulus source: 16-bit LFSR, seeded with 9
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmp(logic [15:0] got, logic [15:0] exp, logic [15:0] m);
    n_compared++;
    if ((got & m) !== (exp & m))
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One bus cycle, word wide only; strobes change once per edge
  task automatic bus(logic w, logic r, logic [8:0] ad, logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= d;
  endtask
  task automatic idle(int n);
    repeat (n) bus(0, 0, reg_addr, 16'h0000);
  endtask
  task automatic rd(logic [8:0] ad, logic [15:0] e, logic [15:0] m);
    exp_q.push_back({m, e});
    bus(0, 1, ad, 16'h0000);
  endtask
  // Counter reads two gap cycles apart; the step is what counts
  // Takes the newest two results, so stray earlier reads cannot shift it
  task automatic delta(logic [8:0] ad, int gap, logic [15:0] want);
    rd(ad, 16'h0000, 16'h0000);
    idle(gap - 1);
    rd(ad, 16'h0000, 16'h0000);
    idle(2);
    b = got_q.pop_back();
    a = got_q.pop_back();
    got_q.delete();
    cmp(b - a, want, 16'hFFFF);
  endtask
  // Read result checked mid-cycle, away from the edge that updates it
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk)
  begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      cmp(reg_rdata, note[15:0], note[31:16]);
      got_q.push_back(reg_rdata);
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog: tests need about 2100 cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
  initial
  begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    lfsr = 16'h0009;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      rd({lfsr[8:1], 1'b0} | 9'h004, 16'h0000, 16'hFFFF);
      bus(1, 0, IRQ, lfsr);
      rd(IRQ, lfsr & 16'h07F0, 16'hFFFF);
    end
    idle(2);
    got_q.delete();
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1, 0, MCR, cfg(0, i[1:0], 0, 0, i[2]));
      idle(8);
      delta(T1, (i[2] ? 4 : 32) << i[1:0], 16'h0001);
    end
    $display("counter one test done");
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 0, MCR, cfg(0, 0, i[1:0], 1, 0));
      pin_source_inst.level(1'b0);
      idle(12);
      delta(T2, 64, 16'h0000);
      pin_source_inst.level(1'b1);
      idle(12);
      delta(T2, 8 << i, 16'h0001);
      pin_source_inst.level(1'b0);
    end
    // Clock mode: one-cycle glitches must be filtered out
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 0, MCR, cfg(0, 0, i[1:0], 0, 1));
      idle(12);
      rd(T2, 16'h0000, 16'h0000);
      idle(2);
      c = got_q.pop_back();
      repeat (8)
      begin
        pin_source_inst.pulse(1, 4);
        pin_source_inst.pulse(8, 8);
      end
      delta(T2, 4, 16'h0000);
      cmp(b - c, 16'h0008 >> i, 16'hFFFF);
    end
    $display("counter two test done");
    bus(1, 0, MCR, cfg(1, 0, 0, 0, 1));
    idle(4);
    rd(MCR, 16'h8120, 16'hFFFF);
    idle(1);
    delta(T1, 64, 16'h0000);
    bus(1, 0, MCR, 16'h0000);
    idle(4);
    cmp({15'h0000, stop_flag}, 16'h0000, 16'hFFFF);
    $display("stop test done");
    reset_n <= 1'b0;
    idle(12);
    reset_n <= 1'b1;
    rd(MCR, 16'h0000, 16'hFFFF);
    rd(T1, 16'h0000, 16'hFFFF);
    rd(T2, 16'h0000, 16'hFFFF);
    bus(1, 0, MCR, 16'h0080);
    bus(1, 0, MCR, 16'h0000);
    idle(2);
    cmp({15'h0000, emulation_enable}, 16'h0001, 16'hFFFF);
    rd(MCR, 16'h0080, 16'hFFFF);
    idle(3);
    $display("emulation test done");
    wrap_up();
  end
endmodule // dual_timebase_prescaler_tb_top
